// File: design/bstap_map.svh
// Constants of the boundary-scan test port and probe pin sharing
`ifndef BSTAP_MAP_SVH
`define BSTAP_MAP_SVH

// Instruction register
`define BSTAP_IR_W        4
`define BSTAP_IR_EXTEST   4'h0
`define BSTAP_IR_SAMPLE   4'h1
`define BSTAP_IR_IDCODE   4'h2
`define BSTAP_IR_BYPASS   4'hF
`define BSTAP_IR_CAPTURE  4'h1
`define BSTAP_IR_RESET    4'h2

// Identification register fields
`define BSTAP_ID_W        32
`define BSTAP_ID_LSB_BIT  0
`define BSTAP_ID_NUM_LO   1
`define BSTAP_ID_NUM_HI   11
`define BSTAP_ID_PART_LO  12
`define BSTAP_ID_PART_HI  27
`define BSTAP_ID_VER_LO   28
`define BSTAP_ID_VER_HI   31
`define BSTAP_ID_LSB_VAL  1'h1

// Shared probe pins, one boundary cell each
`define BSTAP_PINS                 5
`define BSTAP_PROBE_CHANNEL_A_OUT  0
`define BSTAP_PROBE_CHANNEL_B_OUT  1
`define BSTAP_PROBE_SERIAL_IN      2
`define BSTAP_PROBE_SERIAL_OUT     3
`define BSTAP_PROBE_SHIFT_CLOCK    4

// Timing count in test clock cycles and synchroniser width in bits
`define BSTAP_RESET_TMS_CYCLES     5
`define BSTAP_SYNC_W               10

`endif

// File: design/bstap_pkg.sv
// Types of the boundary-scan test port
package bstap_pkg;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bstap_state_type;

  typedef enum logic [1:0] {
    SHARE_USER, SHARE_PROBE, SHARE_SECURED
  } bstap_share_type;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDCODE, SEL_BOUNDARY
  } bstap_dr_type;

endpackage

// File: design/bstap_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module bstap_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

// File: design/bstap_top.sv
// Boundary-scan test port with probe pin sharing
`timescale 1ns/10ps
`default_nettype none
`include "bstap_map.svh"

module bstap_top #(
  parameter logic [3:0]  ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART    = 16'h0001,
  parameter logic [10:0] ID_NUMBER  = 11'h001
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Test access port
  input  wire logic       TCK,
  input  wire logic       TMS,
  input  wire logic       TDI,
  output logic            TDO,
  output logic            TDO_OE,
  // Probe configuration
  input  wire logic       FUSE_PROGRAMMED,
  input  wire logic       PROBE_MODE,
  // Shared pins
  input  wire logic [4:0] PIN_I,
  output logic      [4:0] PIN_O,
  output logic      [4:0] PIN_OE,
  // User design side
  input  wire logic [4:0] USER_ASSIGNED,
  input  wire logic [4:0] USER_O,
  input  wire logic [4:0] USER_OE,
  output logic      [4:0] USER_I,
  // Probe circuit side
  input  wire logic       PROBE_CHANNEL_A_SRC,
  input  wire logic       PROBE_CHANNEL_B_SRC,
  output logic            PROBE_SERIAL_IN,
  output logic            PROBE_SERIAL_OUT,
  output logic            PROBE_SHIFT_CLOCK,
  output logic            PROBE_ACTIVE
);
  localparam int IRW = `BSTAP_IR_W;
  localparam int NP  = `BSTAP_PINS;
  localparam int IDW = `BSTAP_ID_W;
  localparam logic [IDW-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_NUMBER, `BSTAP_ID_LSB_VAL};

  // Synchronised inputs
  logic [`BSTAP_SYNC_W-1:0] sync_in;
  logic [`BSTAP_SYNC_W-1:0] sync_out;
  logic                     tck_s;
  logic                     tms_s;
  logic                     tdi_s;
  logic                     fuse_s;
  logic                     mode_s;
  logic [NP-1:0]            pin_s;

  assign sync_in = {PIN_I, PROBE_MODE, FUSE_PROGRAMMED, TDI, TMS, TCK};

  bstap_sync #(.W(`BSTAP_SYNC_W)) u_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   (sync_in),
    .q   (sync_out)
  );

  assign tck_s  = sync_out[0];
  assign tms_s  = sync_out[1];
  assign tdi_s  = sync_out[2];
  assign fuse_s = sync_out[3];
  assign mode_s = sync_out[4];
  assign pin_s  = sync_out[9:5];

  // Standard sixteen-state step on TMS
  function automatic bstap_pkg::bstap_state_type tap_next(bstap_pkg::bstap_state_type s, logic m);
    case (s)
      bstap_pkg::TLR:    tap_next = m ? bstap_pkg::TLR    : bstap_pkg::RTI;
      bstap_pkg::RTI:    tap_next = m ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
      bstap_pkg::SEL_DR: tap_next = m ? bstap_pkg::SEL_IR : bstap_pkg::CAP_DR;
      bstap_pkg::CAP_DR: tap_next = m ? bstap_pkg::EX1_DR : bstap_pkg::SH_DR;
      bstap_pkg::SH_DR:  tap_next = m ? bstap_pkg::EX1_DR : bstap_pkg::SH_DR;
      bstap_pkg::EX1_DR: tap_next = m ? bstap_pkg::UPD_DR : bstap_pkg::PA_DR;
      bstap_pkg::PA_DR:  tap_next = m ? bstap_pkg::EX2_DR : bstap_pkg::PA_DR;
      bstap_pkg::EX2_DR: tap_next = m ? bstap_pkg::UPD_DR : bstap_pkg::SH_DR;
      bstap_pkg::UPD_DR: tap_next = m ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
      bstap_pkg::SEL_IR: tap_next = m ? bstap_pkg::TLR    : bstap_pkg::CAP_IR;
      bstap_pkg::CAP_IR: tap_next = m ? bstap_pkg::EX1_IR : bstap_pkg::SH_IR;
      bstap_pkg::SH_IR:  tap_next = m ? bstap_pkg::EX1_IR : bstap_pkg::SH_IR;
      bstap_pkg::EX1_IR: tap_next = m ? bstap_pkg::UPD_IR : bstap_pkg::PA_IR;
      bstap_pkg::PA_IR:  tap_next = m ? bstap_pkg::EX2_IR : bstap_pkg::PA_IR;
      bstap_pkg::EX2_IR: tap_next = m ? bstap_pkg::UPD_IR : bstap_pkg::SH_IR;
      bstap_pkg::UPD_IR: tap_next = m ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
      default:           tap_next = bstap_pkg::TLR;
    endcase
  endfunction

  // TAP state and registers
  bstap_pkg::bstap_state_type state_q, state_d;
  bstap_pkg::bstap_dr_type    dr_sel;
  logic            tck_q;
  logic            tck_rise;
  logic            tck_fall;
  logic [IRW-1:0]  ir_q, ir_d;
  logic [IRW-1:0]  ir_sh_q, ir_sh_d;
  logic            byp_q, byp_d;
  logic [IDW-1:0]  id_sh_q, id_sh_d;
  logic [NP-1:0]   bsr_sh_q, bsr_sh_d;
  logic [NP-1:0]   bsr_upd_q, bsr_upd_d;
  logic            tdo_q, tdo_d;
  logic            tdo_oe_q, tdo_oe_d;
  logic            extest;

  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;
  assign extest   = (ir_q == `BSTAP_IR_EXTEST);

  // Data register selection, bypass for anything else
  always_comb begin
    case (ir_q)
      `BSTAP_IR_EXTEST: dr_sel = bstap_pkg::SEL_BOUNDARY;
      `BSTAP_IR_SAMPLE: dr_sel = bstap_pkg::SEL_BOUNDARY;
      `BSTAP_IR_IDCODE: dr_sel = bstap_pkg::SEL_IDCODE;
      default:          dr_sel = bstap_pkg::SEL_BYPASS;
    endcase
  end

  always_comb begin
    state_d   = state_q;
    ir_d      = ir_q;
    ir_sh_d   = ir_sh_q;
    byp_d     = byp_q;
    id_sh_d   = id_sh_q;
    bsr_sh_d  = bsr_sh_q;
    bsr_upd_d = bsr_upd_q;
    tdo_d     = tdo_q;
    tdo_oe_d  = tdo_oe_q;
    if (tck_rise) begin
      state_d = tap_next(state_q, tms_s);
      case (state_q)
        bstap_pkg::CAP_IR: ir_sh_d = `BSTAP_IR_CAPTURE;
        bstap_pkg::SH_IR:  ir_sh_d = {tdi_s, ir_sh_q[IRW-1:1]};
        bstap_pkg::CAP_DR: begin
          case (dr_sel)
            bstap_pkg::SEL_IDCODE:   id_sh_d  = ID_VALUE;
            bstap_pkg::SEL_BOUNDARY: bsr_sh_d = pin_s;
            default:                 byp_d    = 1'b0;
          endcase
        end
        bstap_pkg::SH_DR: begin
          case (dr_sel)
            bstap_pkg::SEL_IDCODE:   id_sh_d  = {tdi_s, id_sh_q[IDW-1:1]};
            bstap_pkg::SEL_BOUNDARY: bsr_sh_d = {tdi_s, bsr_sh_q[NP-1:1]};
            default:                 byp_d    = tdi_s;
          endcase
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      tdo_oe_d = (state_q == bstap_pkg::SH_IR) || (state_q == bstap_pkg::SH_DR);
      case (state_q)
        bstap_pkg::SH_IR: tdo_d = ir_sh_q[0];
        bstap_pkg::SH_DR: begin
          case (dr_sel)
            bstap_pkg::SEL_IDCODE:   tdo_d = id_sh_q[0];
            bstap_pkg::SEL_BOUNDARY: tdo_d = bsr_sh_q[0];
            default:                 tdo_d = byp_q;
          endcase
        end
        bstap_pkg::UPD_IR: ir_d = ir_sh_q;
        bstap_pkg::UPD_DR: begin
          if (dr_sel == bstap_pkg::SEL_BOUNDARY) begin
            bsr_upd_d = bsr_sh_q;
          end
        end
        default: begin
        end
      endcase
    end
    if (state_q == bstap_pkg::TLR) begin
      ir_d = `BSTAP_IR_RESET;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q   <= bstap_pkg::TLR;
      tck_q     <= 1'b0;
      ir_q      <= `BSTAP_IR_RESET;
      ir_sh_q   <= '0;
      byp_q     <= 1'b0;
      id_sh_q   <= '0;
      bsr_sh_q  <= '0;
      bsr_upd_q <= '0;
      tdo_q     <= 1'b0;
      tdo_oe_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      tck_q     <= tck_s;
      ir_q      <= ir_d;
      ir_sh_q   <= ir_sh_d;
      byp_q     <= byp_d;
      id_sh_q   <= id_sh_d;
      bsr_sh_q  <= bsr_sh_d;
      bsr_upd_q <= bsr_upd_d;
      tdo_q     <= tdo_d;
      tdo_oe_q  <= tdo_oe_d;
    end
  end

  assign TDO    = tdo_q;
  assign TDO_OE = tdo_oe_q;

  // Pin sharing
  bstap_pkg::bstap_share_type share;
  logic [NP-1:0] pin_o_q, pin_o_d;
  logic [NP-1:0] pin_oe_q, pin_oe_d;
  logic [NP-1:0] user_i_q, user_i_d;
  logic [2:0]    probe_in_q, probe_in_d;

  always_comb begin
    if (fuse_s) begin
      share = bstap_pkg::SHARE_SECURED;
    end else if (mode_s) begin
      share = bstap_pkg::SHARE_PROBE;
    end else begin
      share = bstap_pkg::SHARE_USER;
    end
  end

  always_comb begin
    pin_o_d    = USER_O & USER_ASSIGNED;
    pin_oe_d   = USER_OE & USER_ASSIGNED;
    user_i_d   = pin_s & USER_ASSIGNED;
    probe_in_d = 3'h0;
    case (share)
      bstap_pkg::SHARE_PROBE: begin
        pin_o_d  = '0;
        pin_oe_d = '0;
        user_i_d = '0;
        pin_o_d[`BSTAP_PROBE_CHANNEL_A_OUT]  = PROBE_CHANNEL_A_SRC;
        pin_o_d[`BSTAP_PROBE_CHANNEL_B_OUT]  = PROBE_CHANNEL_B_SRC;
        pin_oe_d[`BSTAP_PROBE_CHANNEL_A_OUT] = 1'b1;
        pin_oe_d[`BSTAP_PROBE_CHANNEL_B_OUT] = 1'b1;
        probe_in_d = {pin_s[`BSTAP_PROBE_SHIFT_CLOCK], pin_s[`BSTAP_PROBE_SERIAL_OUT],
                      pin_s[`BSTAP_PROBE_SERIAL_IN]};
      end
      bstap_pkg::SHARE_SECURED: probe_in_d = 3'h0;
      default: begin
      end
    endcase
    if (extest) begin
      pin_o_d  = bsr_upd_q;
      pin_oe_d = '1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_o_q    <= '0;
      pin_oe_q   <= '0;
      user_i_q   <= '0;
      probe_in_q <= 3'h0;
    end else begin
      pin_o_q    <= pin_o_d;
      pin_oe_q   <= pin_oe_d;
      user_i_q   <= user_i_d;
      probe_in_q <= probe_in_d;
    end
  end

  assign PIN_O             = pin_o_q;
  assign PIN_OE            = pin_oe_q;
  assign USER_I            = user_i_q;
  assign PROBE_SERIAL_IN   = probe_in_q[0];
  assign PROBE_SERIAL_OUT  = probe_in_q[1];
  assign PROBE_SHIFT_CLOCK = probe_in_q[2];
  assign PROBE_ACTIVE      = (share == bstap_pkg::SHARE_PROBE);

  // Helper: run of test clock rises with TMS high
  logic [2:0] tms_run_q;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tms_run_q <= 3'h0;
    end else if (tck_rise) begin
      tms_run_q <= !tms_s ? 3'h0 : (tms_run_q == 3'h7) ? 3'h7 : tms_run_q + 3'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_power_up_tlr: assert property ($past(SYS_RST) |-> state_q == bstap_pkg::TLR)
    else $error("TAP not in reset state after power-up");
  a_tms_five_reset: assert property (tms_run_q >= 3'h5 |-> state_q == bstap_pkg::TLR)
    else $error("Five TMS-high clocks did not reset the TAP");
  a_state_holds_idle: assert property (!tck_rise |=> $stable(state_q))
    else $error("TAP moved without a test clock rise");
  a_tlr_to_idle: assert property (state_q == bstap_pkg::TLR && tck_rise && !tms_s |=> state_q == bstap_pkg::RTI)
    else $error("TAP did not leave reset on TMS low");
  a_ir_reset_id: assert property (state_q == bstap_pkg::TLR |=> ir_q == `BSTAP_IR_IDCODE)
    else $error("Instruction not reset to identification");
  a_bypass_path: assert property (tck_fall && state_q == bstap_pkg::SH_DR && dr_sel == bstap_pkg::SEL_BYPASS
                                  |=> tdo_q == $past(byp_q) && tdo_oe_q)
    else $error("Bypass bit not presented on TDO");
  a_id_capture: assert property (tck_rise && state_q == bstap_pkg::CAP_DR && ir_q == `BSTAP_IR_IDCODE
                                 |=> id_sh_q == ID_VALUE)
    else $error("Identification value not captured");
  a_extest_drive: assert property (extest ##1 extest |-> pin_oe_q == 5'h1F && pin_o_q == $past(bsr_upd_q))
    else $error("Boundary cells not driving pins under external test");
  a_probe_pins: assert property (!fuse_s && mode_s && !extest |=> pin_oe_q == 5'h03 && user_i_q == 5'h00)
    else $error("Probe pin sharing wrong in high mode");
  a_unused_pin: assert property (!fuse_s && !mode_s && !extest |=> (pin_oe_q & ~$past(USER_ASSIGNED)) == 5'h00)
    else $error("Unassigned shared pin is driven");
  a_tdo_quiet: assert property (tck_fall && state_q == bstap_pkg::TLR |=> !tdo_oe_q)
    else $error("TDO driven outside shift states");
endmodule
`default_nettype wire

// File: sim/bstap_tester.sv
// Tester model that walks the test port from outside
`timescale 1ns/10ps
`default_nettype none
module bstap_tester (
  // Clock
  input  wire logic clk,
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock, 5 CLK low then 3 high; TMS and TDI set at the fall
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge clk);
    tck <= 1'b1;
    #1;
    o = tdo_oe ? tdo : 1'bx;
    repeat (2) @(posedge clk);
  endtask

  // Five clocks with TMS high, then on to Run-Test/Idle
  task automatic reset5();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask

  // Scan from Run-Test/Idle back to Run-Test/Idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule
`default_nettype wire

// File: sim/bstap_top_tb.sv
// Self-checking bench for the test port and probe pin sharing
`timescale 1ns/10ps
`default_nettype none
module bstap_top_tb;
  // Identification values, arbitrary
  localparam logic [3:0]  VER  = 4'hA;
  localparam logic [15:0] PART = 16'h5A3C;
  localparam logic [10:0] NUM  = 11'h2B5;
  localparam logic [31:0] ID   = {VER, PART, NUM, 1'b1};

  logic        clk, sys_rst, fuse, mode, a_src, b_src;
  logic        tck, tms, tdi, tdo, tdo_oe, o;
  logic [4:0]  pin_i, pin_o, pin_oe, ext, assigned, user_o, user_oe, user_i;
  logic        ser_in, ser_out, shift_clk, active;
  logic [31:0] got;
  int          n_mismatch;
  int          n_tests;

  // Pin level from device drive or outside drive
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  bstap_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_NUMBER(NUM)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
    .FUSE_PROGRAMMED(fuse), .PROBE_MODE(mode), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .USER_ASSIGNED(assigned), .USER_O(user_o), .USER_OE(user_oe), .USER_I(user_i),
    .PROBE_CHANNEL_A_SRC(a_src), .PROBE_CHANNEL_B_SRC(b_src), .PROBE_SERIAL_IN(ser_in),
    .PROBE_SERIAL_OUT(ser_out), .PROBE_SHIFT_CLOCK(shift_clk), .PROBE_ACTIVE(active));

  bstap_tester i_tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Identification read straight after reset
  task automatic t_reset_id();
    check("tdo_oe idle", 1'b0, tdo_oe);
    i_tst.step(1'b0, 1'b0, o);
    i_tst.scan(1'b0, 32, 32'h0, got);
    check("idcode", ID, got);
  endtask

  // Bypass by code and by unknown code, then five-clock reset
  task automatic t_bypass();
    logic [3:0] codes [2] = '{4'hF, 4'h7};
    foreach (codes[k]) begin
      i_tst.scan(1'b1, 4, {28'h0, codes[k]}, got);
      check("ir capture", 32'h1, got);
      i_tst.scan(1'b0, 8, 32'hA5, got);
      check("bypass", 32'h4A, got);
    end
    i_tst.step(1'b1, 1'b0, o);
    i_tst.step(1'b0, 1'b0, o);
    i_tst.step(1'b0, 1'b0, o);
    i_tst.reset5();
    i_tst.scan(1'b0, 32, 32'h0, got);
    check("idcode after tms", ID, got);
  endtask

  // Sample, preload and external test on the boundary cells
  task automatic t_boundary();
    ext <= 5'h16;
    i_tst.scan(1'b1, 4, 32'h1, got);
    i_tst.scan(1'b0, 5, 32'h09, got);
    check("sample capture", 32'h16, got);
    check("sample no drive", 5'h00, pin_oe);
    i_tst.scan(1'b1, 4, 32'h0, got);
    check("extest oe", 5'h1F, pin_oe);
    check("preload value", 5'h09, pin_o);
    i_tst.scan(1'b0, 5, 32'h0B, got);
    check("extest capture", 32'h09, got);
    check("extest drive", 5'h0B, pin_o);
    i_tst.reset5();
    check("drive off", 5'h00, pin_oe);
  endtask

  // One sharing setting and its expected pin results
  task automatic share(input logic f, input logic m, input logic [4:0] eoe, input logic [4:0] eui,
                       input logic eact, input logic [2:0] epr);
    fuse <= f;
    mode <= m;
    repeat (8) @(posedge clk);
    check("pin oe", eoe, pin_oe);
    check("user in", eui, user_i);
    check("active", eact, active);
    check("probe in", epr, {shift_clk, ser_out, ser_in});
    if (m && !f) begin
      check("probe out", {b_src, a_src}, pin_o[1:0]);
    end else begin
      check("user drive", 5'h11, pin_o & 5'h15);
    end
  endtask

  task automatic t_share();
    assigned <= 5'h1D;
    user_oe <= 5'h15;
    user_o <= 5'h11;
    ext <= 5'h0E;
    a_src <= 1'b1;
    share(1'b0, 1'b0, 5'h15, 5'h19, 1'b0, 3'h0);
    share(1'b0, 1'b1, 5'h03, 5'h00, 1'b1, 3'h3);
    share(1'b1, 1'b1, 5'h15, 5'h19, 1'b0, 3'h0);
  endtask

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {fuse, mode, a_src, b_src} = 4'h0;
    {ext, assigned, user_o, user_oe} = 20'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_id();
    t_bypass();
    t_boundary();
    t_share();
    report_and_stop();
  end

  initial begin
    #500us;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
